// ---- rtl/sfr_fault_readout.sv ----
// Serial fault status readout core with serial link
`timescale 1ns/10ps
`default_nettype none
module sfr_fault_readout (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic chip_select_n_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_oe_out,
	input wire logic [sfr_pkg::NCH-1:0] ots_in,
	input wire logic [sfr_pkg::NCH-1:0] otw_in,
	input wire logic [sfr_pkg::NCH*sfr_pkg::OC_W-1:0] oc_code_in,
	input wire logic [sfr_pkg::NCH-1:0] olon_in,
	input wire logic [sfr_pkg::NCH-1:0] oloff_in,
	input wire logic charge_pump_fault_in,
	input wire logic pwm_clock_fault_in,
	input wire logic overvoltage_in,
	input wire logic undervoltage_in,
	input wire logic factory_test_in,
	input wire logic serial_link_fail_in,
	input wire logic fail_mode_in,
	input wire logic sleep_mode_in,
	input wire logic limp_input_level_in,
	input wire logic [sfr_pkg::NIN-1:0] deglitched_input_level_in,
	input wire logic [sfr_pkg::NIN-1:0] input_toggle_activity_in,
	input wire logic [sfr_pkg::NCH-1:0] output_cmp_in,
	input wire logic sense_sample_sync_in,
	output logic [sfr_pkg::MUX_W-1:0] feedback_source_select_out,
	output logic feedback_enable_out,
	output logic [sfr_pkg::NCH-1:0] advanced_sense_mode_out,
	output logic [sfr_pkg::NCH-1:0] sense_offset_invert_out
);
	import sfr_pkg::*;

	// Quick word for select zero and unused codes
	function automatic logic [SEL_W-1:0] norm_sel(input logic [SEL_W-1:0] s);
		norm_sel = (s == SEL_NONE || s > SEL_ID) ? SEL_QUICK : s;
	endfunction

	sfr_link_if lnk ();

	logic rst_s1_ff, rst_s2_ff, rst_n;
	sfr_pins_t raw, pin_s1_ff, pin_s2_ff;
	logic cs_s1_ff, cs_s2_ff, cs_act;
	logic tg_s1_ff, tg_s2_ff, tg_s3_ff, frame_done;
	logic [NCH-1:0][OC_W-1:0] oc_prev_ff, oc_ff;
	logic [NCH-1:0] ots_ff, otw_ff, olon_ff, oloff_ff;
	logic cpf_ff, pwm_clock_fault_ff, ovf_ff, uvf_ff, tmf_ff, serial_link_fail_flag_ff, rcf_ff;
	logic [SEL_W-1:0] sel_ff, eff_sel, tx_sel_ff, rx_adr;
	logic persist_ff;
	logic [MUX_W-1:0] mux_ff;
	logic [NCH-1:0] acm_en_ff, acm_act, inv_ff, nxt_inv;
	logic ss_prev_ff, ss_rise;
	logic [WORD_W-1:0] tx_ff, word_sel, quick_w, dev_w, io_w, id_w;
	logic [NCH-1:0][WORD_W-1:0] ch_w;
	logic [NCH-1:0] qsf, oc_evt, ch_clr, oc_any;
	logic dev_clr, wr_init, wr_acm;
	logic device_summary_flag, overload_summary_flag, open_load_summary_flag, tog_any;

	// Reset release through two flops
	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end
	assign rst_n = rst_s2_ff;

	// Pin bundle
	assign raw = '{ots: ots_in, otw: otw_in, oc: oc_code_in, olon: olon_in,
		oloff: oloff_in, charge_pump_fault: charge_pump_fault_in, pwm_clock_fault: pwm_clock_fault_in,
		ovf: overvoltage_in, undervoltage_flag: undervoltage_in, factory_test_flag: factory_test_in,
		serial_link_fail_flag: serial_link_fail_in, fail: fail_mode_in, sleep: sleep_mode_in,
		limp: limp_input_level_in, din: deglitched_input_level_in,
		tog: input_toggle_activity_in, outc: output_cmp_in,
		ssync: sense_sample_sync_in};

	// Two-flop synchronisers for pins, select and frame event
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			cs_s1_ff <= 1'b1;
			cs_s2_ff <= 1'b1;
			tg_s1_ff <= 1'b0;
			tg_s2_ff <= 1'b0;
			tg_s3_ff <= 1'b0;
		end
		else
		begin
			pin_s1_ff <= raw;
			pin_s2_ff <= pin_s1_ff;
			cs_s1_ff <= chip_select_n_in;
			cs_s2_ff <= cs_s1_ff;
			tg_s1_ff <= lnk.done_tgl;
			tg_s2_ff <= tg_s1_ff;
			tg_s3_ff <= tg_s2_ff;
		end
	end

	// Frame decode
	assign cs_act = !cs_s2_ff;
	assign frame_done = tg_s2_ff ^ tg_s3_ff;
	assign rx_adr = lnk.rx_word[RX_ADR_LO +: SEL_W];
	assign wr_init = frame_done && (rx_adr == ADR_INIT1);
	assign wr_acm = frame_done && (rx_adr == ADR_ACM);
	assign dev_clr = frame_done && (tx_sel_ff == SEL_DEV);

	// Per-channel flags, cleared by reading the channel word
	generate
		for (genvar i = 0; i < NCH; i++)
		begin : g_ch
			assign ch_clr[i] = frame_done && (tx_sel_ff == 4'(SEL_CH1 + i));
			assign oc_evt[i] = (pin_s2_ff.oc[i] != OC_NONE) &&
				(pin_s2_ff.oc[i] == oc_prev_ff[i]);
			assign oc_any[i] = (oc_ff[i] != OC_NONE);
			assign qsf[i] = oc_any[i] | otw_ff[i] | ots_ff[i] | olon_ff[i] | oloff_ff[i];
			assign ch_w[i] = {4'(SEL_CH1 + i), pin_s2_ff.fail, device_summary_flag, overload_summary_flag, open_load_summary_flag, 1'b0,
				ots_ff[i], otw_ff[i], oc_ff[i], olon_ff[i], oloff_ff[i]};

			// Latch with set winning over a simultaneous clear
			always_ff @(posedge clock_in or negedge rst_n)
			begin
				if (!rst_n)
				begin
					ots_ff[i] <= 1'b0;
					otw_ff[i] <= 1'b0;
					olon_ff[i] <= 1'b0;
					oloff_ff[i] <= 1'b0;
					oc_ff[i] <= OC_NONE;
					oc_prev_ff[i] <= OC_NONE;
				end
				else
				begin
					ots_ff[i] <= (ots_ff[i] & ~ch_clr[i]) | pin_s2_ff.ots[i];
					otw_ff[i] <= (otw_ff[i] & ~ch_clr[i]) | pin_s2_ff.otw[i];
					olon_ff[i] <= (olon_ff[i] & ~ch_clr[i]) | pin_s2_ff.olon[i];
					oloff_ff[i] <= (oloff_ff[i] & ~ch_clr[i]) | pin_s2_ff.oloff[i];
					oc_prev_ff[i] <= pin_s2_ff.oc[i];
					if (oc_evt[i])
						oc_ff[i] <= pin_s2_ff.oc[i];
					else if (ch_clr[i])
						oc_ff[i] <= OC_NONE;
				end
			end
		end
	endgenerate

	// Device flags, cleared by reading the device word
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpf_ff <= 1'b0;
			pwm_clock_fault_ff <= 1'b0;
			ovf_ff <= 1'b0;
			uvf_ff <= 1'b0;
			tmf_ff <= 1'b0;
			serial_link_fail_flag_ff <= 1'b0;
			rcf_ff <= 1'b1;
		end
		else
		begin
			cpf_ff <= (cpf_ff & ~dev_clr) | pin_s2_ff.charge_pump_fault;
			pwm_clock_fault_ff <= (pwm_clock_fault_ff & ~dev_clr) | pin_s2_ff.pwm_clock_fault;
			ovf_ff <= (ovf_ff & ~dev_clr) | pin_s2_ff.ovf;
			uvf_ff <= (uvf_ff & ~dev_clr) | pin_s2_ff.undervoltage_flag;
			tmf_ff <= (tmf_ff & ~dev_clr) | pin_s2_ff.factory_test_flag;
			serial_link_fail_flag_ff <= (serial_link_fail_flag_ff & ~dev_clr) | pin_s2_ff.serial_link_fail_flag;
			rcf_ff <= rcf_ff & ~dev_clr;
		end
	end

	// Global summary flags
	assign device_summary_flag = rcf_ff | uvf_ff | ovf_ff | cpf_ff | pwm_clock_fault_ff | tmf_ff;
	assign overload_summary_flag = |(oc_any | ots_ff);
	assign open_load_summary_flag = |(olon_ff | oloff_ff);
	assign tog_any = |pin_s2_ff.tog;

	// Fixed words
	assign quick_w = {SEL_QUICK, pin_s2_ff.fail, device_summary_flag, overload_summary_flag, open_load_summary_flag,
		cpf_ff, rcf_ff, pwm_clock_fault_ff, qsf};
	assign dev_w = {SEL_DEV, pin_s2_ff.fail, device_summary_flag, overload_summary_flag, open_load_summary_flag, 3'b000,
		tmf_ff, ovf_ff, uvf_ff, serial_link_fail_flag_ff, pin_s2_ff.limp};
	assign io_w = {SEL_IO, pin_s2_ff.fail, 1'b0, tog_any,
		pin_s2_ff.din, pin_s2_ff.outc};
	assign id_w = {SEL_ID, pin_s2_ff.fail, 3'b000,
		uvf_ff ? UV_CODE : PART_CODE};

	// Word selection
	assign eff_sel = norm_sel(sel_ff);
	always_comb
	begin
		case (eff_sel)
			SEL_DEV: word_sel = dev_w;
			SEL_IO: word_sel = io_w;
			SEL_ID: word_sel = id_w;
			SEL_QUICK: word_sel = quick_w;
			default:
			begin
				if (eff_sel >= SEL_CH1 && eff_sel <= SEL_CH5)
					word_sel = ch_w[3'(eff_sel - SEL_CH1)];
				else
					word_sel = quick_w;
			end
		endcase
	end

	// Output word frozen while the frame runs
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_ff <= '0;
			tx_sel_ff <= SEL_QUICK;
		end
		else if (!cs_act)
		begin
			tx_ff <= word_sel;
			tx_sel_ff <= eff_sel;
		end
	end
	assign lnk.tx_word = tx_ff;

	// Init register one and advanced sense enables
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_ff <= SEL_QUICK;
			persist_ff <= 1'b0;
			mux_ff <= '0;
			acm_en_ff <= '0;
		end
		else
		begin
			if (wr_init)
			begin
				sel_ff <= lnk.rx_word[F_SEL_LO +: SEL_W];
				persist_ff <= lnk.rx_word[F_PERSIST];
				mux_ff <= lnk.rx_word[F_MUX_LO +: MUX_W];
			end
			else if (frame_done && !persist_ff)
				sel_ff <= SEL_QUICK;
			if (pin_s2_ff.fail)
				acm_en_ff <= '0;
			else if (wr_acm)
				acm_en_ff <= lnk.rx_word[F_ACM_LO +: NCH];
		end
	end

	// Offset polarity flips on each sense-sync rising edge
	assign acm_act = pin_s2_ff.fail ? '0 : acm_en_ff;
	assign ss_rise = pin_s2_ff.ssync & ~ss_prev_ff;
	assign nxt_inv = ss_rise ? (inv_ff ^ acm_act) & acm_act : inv_ff & acm_act;
	always_ff @(posedge clock_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ss_prev_ff <= 1'b0;
			inv_ff <= '0;
		end
		else
		begin
			ss_prev_ff <= pin_s2_ff.ssync;
			inv_ff <= nxt_inv;
		end
	end

	// Analog control outputs
	assign feedback_source_select_out = mux_ff;
	assign feedback_enable_out = !pin_s2_ff.fail && !pin_s2_ff.sleep;
	assign advanced_sense_mode_out = acm_act;
	assign sense_offset_invert_out = inv_ff;

	// Serial link side
	sfr_serial_shift u_shift (
		.serial_clock_in(serial_clock_in),
		.chip_select_n_in(chip_select_n_in),
		.rst_n_in(rst_n),
		.serial_data_in(serial_data_in),
		.serial_data_out(serial_data_out),
		.lnk(lnk.shifter)
	);
	assign serial_data_oe_out = !chip_select_n_in;

	// Checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n);

	sequence seq_write_sel;
		wr_init;
	endsequence
	sequence seq_plain_read;
		frame_done && !wr_init;
	endsequence

	chk_write_select: assert property (seq_write_sel |=> sel_ff == $past(lnk.rx_word[3:0]))
		else $error("word select not taken from init write");
	chk_oneshot_revert: assert property (seq_plain_read ##0 !persist_ff |=> sel_ff == SEL_QUICK)
		else $error("single-read select did not revert");
	chk_persist_hold: assert property (seq_plain_read ##0 persist_ff |=> $stable(sel_ff))
		else $error("persistent select changed");
	chk_zero_is_quick: assert property (sel_ff == SEL_NONE |-> eff_sel == SEL_QUICK)
		else $error("select zero not mapped to quick word");
	chk_fail_bit: assert property (!cs_act |=> tx_ff[B_FAIL] == $past(pin_s2_ff.fail))
		else $error("fail bit wrong in word");
	chk_code_top: assert property (!cs_act |=> tx_ff[B_SEL_LO +: SEL_W] == $past(eff_sel))
		else $error("select code missing from word");
	chk_dsf_rcf: assert property (rcf_ff |-> device_summary_flag)
		else $error("cleared flag not in summary");
	chk_overload_summary_flag_ots: assert property ($rose(pin_s2_ff.ots[0]) |=> overload_summary_flag ##1 overload_summary_flag)
		else $error("shutdown not in overload flag");
	chk_set_wins: assert property (ch_clr[0] && pin_s2_ff.ots[0] |=> ots_ff[0])
		else $error("set lost to read clear");
	chk_oc_latch: assert property (oc_evt[0] |=> oc_ff[0] == $past(pin_s2_ff.oc[0]))
		else $error("overcurrent code not latched");
	chk_id_uv: assert property (uvf_ff && eff_sel == SEL_ID && !cs_act |=>
		tx_ff[B_ID_LO +: 8] == UV_CODE)
		else $error("part code not zero under undervoltage");
	chk_acm_fail: assert property (pin_s2_ff.fail |=> acm_en_ff == '0 && advanced_sense_mode_out == '0)
		else $error("advanced sense kept in fail mode");
	chk_offset_flip: assert property (ss_rise && acm_act[0] |=> inv_ff[0] != $past(inv_ff[0]))
		else $error("offset polarity did not flip");
	chk_toggle_or: assert property (!cs_act && eff_sel == SEL_IO |=>
		tx_ff[B_TOGGLE] == $past(tog_any))
		else $error("toggle bit wrong");
endmodule
`default_nettype wire

// ---- pkg/sfr_pkg.sv ----
// Constants, field layout and pin bundle for the serial fault status readout
// How it works
// - Output bits of the I/O word show the live off-state short-to-battery comparator
// - Four-bit word select in init register one picks the shifted-out word
// - Persist bit low: programmed word used for one read, then quick word again
// - Persist bit high: programmed word returned on every read until reprogrammed
// - Select zero means quick word; each word carries its select code on top
// - Bit 11 of every word shows fail mode
// - Global flags in bits 10..8 clear only when every underlying fault is read clear
// - Device summary flag ORs cleared, under, over, pump, clock and test flags
// - Overload summary flag ORs all overcurrent and overtemperature shutdown signals
// - Registers cleared flag set whenever registers return to their defaults
// - Channel quick bit ORs its overcurrent code, temperature and open-load flags
// - One status word per channel, codes 2..6, fixed bit layout
// - Three-bit overcurrent code; a newer event overwrites an unread older one
// - Device status word code 7 with test, over, under, link fail, limp
// - Limp bit reported live after deglitch, never latched
// - I/O word code 8: toggle, deglitched inputs and outputs, all live
// - Toggle bit is live OR of the four input toggle activities
// - ID word code 9 carries part code, forced to zero under undervoltage
// - Three feedback select bits in init register one; no feedback in fail or sleep
// - Advanced sense mode flips offset polarity on each sense-sync rising edge
// - Per-channel advanced sense enable, reset low, forced low in fail mode
package sfr_pkg;
	localparam int WORD_W = 16;
	localparam int NCH = 5;
	localparam int NIN = 4;
	localparam int OC_W = 3;
	localparam int SEL_W = 4;
	localparam int MUX_W = 3;
	// Word select codes
	localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
	localparam logic [SEL_W-1:0] SEL_QUICK = 4'h1;
	localparam logic [SEL_W-1:0] SEL_CH1 = 4'h2;
	localparam logic [SEL_W-1:0] SEL_CH5 = 4'h6;
	localparam logic [SEL_W-1:0] SEL_DEV = 4'h7;
	localparam logic [SEL_W-1:0] SEL_IO = 4'h8;
	localparam logic [SEL_W-1:0] SEL_ID = 4'h9;
	// Incoming frame: target in top nibble, payload below
	localparam int RX_ADR_LO = 12;
	localparam logic [SEL_W-1:0] ADR_INIT1 = 4'h0;
	localparam logic [SEL_W-1:0] ADR_ACM = 4'ha;
	localparam int F_SEL_LO = 0;
	localparam int F_PERSIST = 4;
	localparam int F_MUX_LO = 5;
	localparam int F_ACM_LO = 0;
	// Status word bit positions
	localparam int B_SEL_LO = 12;
	localparam int B_FAIL = 11;
	localparam int B_TOGGLE = 9;
	localparam int B_ID_LO = 0;
	// Overcurrent codes
	localparam logic [OC_W-1:0] OC_NONE = 3'h0;
	localparam logic [OC_W-1:0] OC_HI1 = 3'h1;
	localparam logic [OC_W-1:0] OC_LOW = 3'h4;
	localparam logic [OC_W-1:0] OC_SEVERE = 3'h6;
	localparam logic [OC_W-1:0] OC_UNUSED = 3'h7;
	// Part code: arbitrary value; zero code under undervoltage
	localparam logic [7:0] PART_CODE = 8'h5a;
	localparam logic [7:0] UV_CODE = 8'h00;
	// Serial frame length
	localparam logic [4:0] FRAME_BITS = 5'h10;
	localparam logic [4:0] LAST_BIT = 5'h0f;
	// Asynchronous status pins, synchronised as one bundle
	typedef struct packed {
		logic [NCH-1:0] ots;
		logic [NCH-1:0] otw;
		logic [NCH-1:0][OC_W-1:0] oc;
		logic [NCH-1:0] olon;
		logic [NCH-1:0] oloff;
		logic charge_pump_fault;
		logic pwm_clock_fault;
		logic ovf;
		logic undervoltage_flag;
		logic factory_test_flag;
		logic serial_link_fail_flag;
		logic fail;
		logic sleep;
		logic limp;
		logic [NIN-1:0] din;
		logic [NIN-1:0] tog;
		logic [NCH-1:0] outc;
		logic ssync;
	} sfr_pins_t;
endpackage

// ---- pkg/sfr_link_if.sv ----
// Word exchange between the register core and the serial shifter
`timescale 1ns/10ps
`default_nettype none
interface sfr_link_if;
	logic [sfr_pkg::WORD_W-1:0] tx_word;
	logic [sfr_pkg::WORD_W-1:0] rx_word;
	logic done_tgl;
	modport core (output tx_word, input rx_word, input done_tgl);
	modport shifter (input tx_word, output rx_word, output done_tgl);
endinterface
`default_nettype wire

// ---- rtl/sfr_serial_shift.sv ----
// Serial shifter on the host's link clock
`timescale 1ns/10ps
`default_nettype none
module sfr_serial_shift (
	input wire logic serial_clock_in,
	input wire logic chip_select_n_in,
	input wire logic rst_n_in,
	input wire logic serial_data_in,
	output logic serial_data_out,
	sfr_link_if.shifter lnk
);
	import sfr_pkg::*;

	logic [4:0] cnt_ff;
	logic [WORD_W-2:0] shift_ff;
	logic [WORD_W-1:0] rx_ff;
	logic tgl_ff;
	logic last_bit;

	assign last_bit = (cnt_ff == LAST_BIT);

	// Bit counter, cleared by the frame's own select
	always_ff @(posedge serial_clock_in or posedge chip_select_n_in)
	begin
		if (chip_select_n_in)
			cnt_ff <= 5'h00;
		else if (cnt_ff != FRAME_BITS)
			cnt_ff <= 5'(cnt_ff + 5'h01);
	end

	// Input shift register, no reset needed
	always_ff @(posedge serial_clock_in)
	begin
		shift_ff <= {shift_ff[WORD_W-3:0], serial_data_in};
	end

	// Whole frame captured, event toggled to the core
	always_ff @(posedge serial_clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rx_ff <= '0;
			tgl_ff <= 1'b0;
		end
		else if (last_bit && !chip_select_n_in)
		begin
			rx_ff <= {shift_ff, serial_data_in};
			tgl_ff <= ~tgl_ff;
		end
	end

	// MSB first; next bit appears after each rising edge
	assign serial_data_out = (cnt_ff[4]) ? 1'b0 : lnk.tx_word[~cnt_ff[3:0]];
	assign lnk.rx_word = rx_ff;
	assign lnk.done_tgl = tgl_ff;

	chk_frame_event: assert property (@(posedge serial_clock_in) disable iff (chip_select_n_in)
		last_bit |=> (tgl_ff != $past(tgl_ff)))
		else $error("frame end did not toggle event");
endmodule
`default_nettype wire

// ---- verif/sfr_host_model.sv ----
// Serial host model that runs 16-bit frames on its own link clock
`timescale 1ns/10ps
`default_nettype none
module sfr_host_model (
	output logic cs_n_out,
	output logic sclk_out,
	output logic si_out,
	input wire logic so_in,
	output logic [15:0] rd_word_out
);
	event got;
	// Idle: deselected, link clock still
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b0;
		rd_word_out = 16'h0000;
	end
	// One frame, MSB first; data set after falling edge, read at rising
	task automatic xfer(input logic [15:0] w);
		int k;
		cs_n_out = 1'b0;
		#250;
		for (k = 15; k >= 0; k--)
		begin
			si_out = w[k];
			#15;
			rd_word_out[k] = so_in;
			sclk_out = 1'b1;
			#15;
			sclk_out = 1'b0;
		end
		#15;
		cs_n_out = 1'b1;
		si_out = ~w[0]; // Released line no longer shows last bit
		-> got;
		#350;
	endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the serial fault status readout
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import sfr_pkg::*;
	logic clock_in, rst_n_in, cs_n, sclk, si, so, oe, fb_en;
	logic charge_pump_fault, pwm_clock_fault, ov, uv, tm, serial_link_fail_flag, fail, slp, limp, ssync, pers;
	logic [4:0] ots, otw, olon, oloff, outc, amode, inv, q5, en;
	logic [14:0] oc;
	logic [3:0] din, tog, cur;
	logic [2:0] fb_sel, mux;
	logic [15:0] rd_word, exp_w;
	logic [6:0] l_ch [5];
	logic [6:0] l_dv;
	logic [15:0] exp_q [$];
	logic [31:0] seed, r;
	int num_errors, n_checks, k;
	sfr_fault_readout sfr_fault_readout_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.chip_select_n_in(cs_n), .serial_clock_in(sclk), .serial_data_in(si),
		.serial_data_out(so), .serial_data_oe_out(oe), .ots_in(ots), .otw_in(otw),
		.oc_code_in(oc), .olon_in(olon), .oloff_in(oloff), .charge_pump_fault_in(charge_pump_fault),
		.pwm_clock_fault_in(pwm_clock_fault), .overvoltage_in(ov), .undervoltage_in(uv),
		.factory_test_in(tm), .serial_link_fail_in(serial_link_fail_flag), .fail_mode_in(fail),
		.sleep_mode_in(slp), .limp_input_level_in(limp), .deglitched_input_level_in(din),
		.input_toggle_activity_in(tog), .output_cmp_in(outc), .sense_sample_sync_in(ssync),
		.feedback_source_select_out(fb_sel), .feedback_enable_out(fb_en),
		.advanced_sense_mode_out(amode), .sense_offset_invert_out(inv));
	sfr_host_model sfr_host_model_inst (.cs_n_out(cs_n), .sclk_out(sclk), .si_out(si),
		.so_in(so), .rd_word_out(rd_word));
	// Core clock, 50 ns
	initial
	begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#2;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Expected word from the latched flags and live levels
	function automatic logic [15:0] word(input logic [3:0] s);
		logic [4:0] q;
		logic ovl, open_load_summary_flag, device_summary_flag;
		int i;
		ovl = 1'b0;
		open_load_summary_flag = 1'b0;
		device_summary_flag = |l_dv[6:1];
		for (i = 0; i < 5; i++)
		begin
			q[i] = |l_ch[i];
			ovl |= l_ch[i][6] | (|l_ch[i][4:2]);
			open_load_summary_flag |= |l_ch[i][1:0];
		end
		if (s >= SEL_CH1 && s <= SEL_CH5)
			return {s, fail, device_summary_flag, ovl, open_load_summary_flag, 1'b0, l_ch[s-2]};
		if (s == SEL_DEV)
			return {s, fail, device_summary_flag, ovl, open_load_summary_flag, 3'h0, l_dv[3:1], l_dv[0], limp};
		if (s == SEL_IO)
			return {s, fail, 1'b0, |tog, din, outc};
		if (s == SEL_ID)
			return {s, fail, 3'h0, l_dv[1] ? UV_CODE : PART_CODE};
		return {SEL_QUICK, fail, device_summary_flag, ovl, open_load_summary_flag, l_dv[6:4], q};
	endfunction
	// One frame: note the expected word, then track read-clear and select
	task automatic rd(input logic [15:0] w);
		logic [3:0] e;
		tick(1);
		e = (cur == SEL_NONE || cur > SEL_ID) ? SEL_QUICK : cur;
		exp_q.push_back(word(e));
		if (e >= SEL_CH1 && e <= SEL_CH5)
			l_ch[e-2] = 7'h00;
		if (e == SEL_DEV)
			l_dv = 7'h00;
		if (!pers)
			cur = SEL_QUICK;
		if (w[15:12] == ADR_INIT1)
		begin
			cur = w[3:0];
			pers = w[4];
			mux = w[7:5];
		end
		sfr_host_model_inst.xfer(w);
		tick(1);
	endtask
	task automatic do_reset;
		rst_n_in = 1'b0;
		tick(10);
		rst_n_in = 1'b1;
		tick(6);
		l_ch = '{default: '0};
		l_dv = 7'h20;
		cur = SEL_QUICK;
		pers = 1'b0;
	endtask
	// Channel fault, code a overwritten by code b before any read
	task automatic inj_ch(input int ch, input logic [2:0] a, b, input logic [3:0] f);
		oc = 15'(a) << 3*ch;
		ots = 5'(f[3]) << ch;
		otw = 5'(f[2]) << ch;
		olon = 5'(f[1]) << ch;
		oloff = 5'(f[0]) << ch;
		tick(6);
		oc = 15'(b) << 3*ch;
		tick(6);
		{oc, ots, otw, olon, oloff} = '0;
		tick(6);
		l_ch[ch] = {f[3:2], b, f[1:0]};
	endtask
	// Device fault pulse: {pump, clock, test, over, under, link}
	task automatic inj_dv(input logic [5:0] f);
		{charge_pump_fault, pwm_clock_fault, tm, ov, uv, serial_link_fail_flag} = f;
		tick(6);
		{charge_pump_fault, pwm_clock_fault, tm, ov, uv, serial_link_fail_flag} = '0;
		tick(6);
		l_dv |= {f[5], 1'b0, f[4:0]};
	endtask
	// Compare each returned word with the oldest note
	initial
	begin
		forever
		begin
			@(sfr_host_model_inst.got);
			#1;
			exp_w = exp_q.pop_front();
			check(rd_word, exp_w);
			check(oe, 1'b0);
		end
	end
	// Watchdog
	initial
	begin
		#500000;
		num_errors++;
		finish_test();
	end
	// Main sequence
	initial
	begin
		seed = 32'h94c96e98;
		rst_n_in = 1'b0;
		{ots, otw, olon, oloff, outc, oc, charge_pump_fault, pwm_clock_fault, ov, uv, tm, serial_link_fail_flag} = '0;
		{fail, slp, limp, ssync, din, tog} = '0;
		do_reset();
		check(fb_sel, 3'h0);
		check(amode, 5'h00);
		check(inv, 5'h00);
		rd(16'h1000);
		for (k = 0; k < 6; k++)
		begin
			r = $random(seed);
			inj_ch(k % 5, 3'((k + 1) % 6 + 1), 3'(k + 1), r[3:0]);
			rd({ADR_INIT1, 8'h00, SEL_CH1 + 4'(k % 5)});
			rd(16'h1000);
			rd(16'h1000);
		end
		r = $random(seed);
		{din, tog, outc, limp} = r[13:0];
		rd({ADR_INIT1, 4'h0, r[18:16], 1'b1, SEL_IO});
		check(fb_sel, mux);
		rd(16'h1000);
		r = $random(seed);
		{din, tog, outc, limp} = r[13:0];
		rd(16'h1000);
		rd({ADR_INIT1, 8'h01, SEL_NONE});
		rd(16'h1000);
		rd({ADR_INIT1, 8'h00, 4'hc});
		rd(16'h1000);
		en = 5'($random(seed)) | 5'h01;
		fail = 1'b1;
		rd({ADR_ACM, 7'h00, en});
		check(amode, 5'h00);
		check(fb_en, 1'b0);
		fail = 1'b0;
		tick(4);
		check(amode, 5'h00);
		rd({ADR_ACM, 7'h00, en});
		check(amode, en);
		check(fb_en, 1'b1);
		slp = 1'b1;
		tick(4);
		check(fb_en, 1'b0);
		slp = 1'b0;
		q5 = inv;
		repeat (3)
		begin
			ssync = 1'b1;
			tick(4);
			ssync = 1'b0;
			tick(4);
		end
		check(inv & en, (q5 ^ en) & en);
		for (k = 0; k < 2; k++)
		begin
			r = $random(seed);
			limp = r[6];
			inj_dv({r[5:4], 1'(k), r[2:0]});
			rd({ADR_INIT1, 8'h00, SEL_DEV});
			rd(16'h1000);
			rd(16'h1000);
		end
		do_reset();
		rd(16'h1000);
		uv = 1'b1;
		tick(6);
		l_dv[1] = 1'b1;
		rd({ADR_INIT1, 8'h00, SEL_ID});
		rd(16'h1000);
		uv = 1'b0;
		rd({ADR_INIT1, 8'h00, SEL_DEV});
		rd(16'h1000);
		rd({ADR_INIT1, 8'h00, SEL_ID});
		rd(16'h1000);
		finish_test();
	end
endmodule
`default_nettype wire
